//--- verification/asbc_conv_model.sv
// Behavioural converter answering conversion requests
`default_nettype none

module asbc_conv_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request side
    input wire logic conv_start,
    input wire logic [1:0] conv_channel,
    input wire logic group_b_sel,
    input wire logic [3:0] ch0_input_sel,
    input wire logic [7:0] delay,
    // Answer side
    output logic conv_done,
    output logic [9:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cnt;
    logic [9:0] val;

    // Count down after a request; data holds only around the done pulse
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 9'h000;
            val <= 10'h000;
            conv_done <= 1'b0;
            conv_data <= 10'h000;
        end else begin
            if (conv_start) begin
                cnt <= {1'b0, delay} + 9'h008;
                val <= {2'b10, group_b_sel, conv_channel, ch0_input_sel, 1'b1};
            end else if (cnt != 9'h000) begin
                cnt <= cnt - 9'h001;
            end
            conv_done <= cnt > 9'h001 && cnt < 9'h008;
            // Outside the window the bus toggles so stale data is never trusted
            conv_data <= (cnt != 9'h000 && cnt < 9'h00a) ? val : ~conv_data;
        end
    end
endmodule

`default_nettype wire

//--- verification/asbc_top_properties.sv
// Port-level concurrent checks for the ADC sequencer
`include "asbc_defines.svh"
`default_nettype none

module asbc_top_properties
    import asbc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Analog front end and interrupt
    input wire logic [3:0] sh_sample,
    input wire logic [3:0] ch0_input_sel,
    input wire logic group_b_sel,
    input wire logic [1:0] conv_channel,
    input wire logic conv_start,
    input wire logic irq
);
    logic sim_reg, sim_next, alt_reg, alt_next, scan_reg, scan_next;
    logic [1:0] chc_reg, chc_next;
    logic [15:0] sel_reg, sel_next;
    logic [3:0] lim;

    // Shadow of the configuration, timed like the design's registers
    always_comb begin
        sim_next = sim_reg;
        alt_next = alt_reg;
        scan_next = scan_reg;
        chc_next = chc_reg;
        sel_next = sel_reg;
        if (reg_wr && reg_addr == `ASBC_OFF_CTRL1) sim_next = reg_wdata[4];
        if (reg_wr && reg_addr == `ASBC_OFF_CTRL2) begin
            chc_next = reg_wdata[9:8];
            alt_next = reg_wdata[7];
            scan_next = reg_wdata[10];
        end
        if (reg_wr && reg_addr == `ASBC_OFF_SCAN) sel_next = reg_wdata;
    end

    // Register the shadow
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {sim_reg, alt_reg, scan_reg, chc_reg, sel_reg} <= '0;
        end else begin
            {sim_reg, alt_reg, scan_reg, chc_reg, sel_reg} <=
                {sim_next, alt_next, scan_next, chc_next, sel_next};
        end
    end

    assign lim = (chc_reg == 2'b00) ? 4'h1 : (chc_reg == 2'b01) ? 4'h3 : 4'hf;

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence kick_s;
        conv_start;
    endsequence
    sequence quiet_s;
        !conv_start [*8];
    endsequence

    read_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read");
    irq_hold_a: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
        else $error("interrupt dropped without a write");
    seq_onehot_a: assert property (!$past(sim_reg) |-> $onehot0(sh_sample))
        else $error("several channels sampled in sequential mode");
    sim_group_a: assert property ($past(sim_reg) && sh_sample != 4'h0 |->
        sh_sample == $past(lim))
        else $error("simultaneous sampling incomplete");
    chan_limit_a: assert property ((sh_sample & ~$past(lim)) == 4'h0)
        else $error("unselected channel sampled");
    conv_range_a: assert property (conv_start |-> lim[conv_channel])
        else $error("unselected channel converted");
    alt_off_a: assert property (conv_start && !alt_reg |-> !group_b_sel)
        else $error("group b used with alternation off");
    scan_pick_a: assert property (conv_start && scan_reg && conv_channel == 2'd0 |->
        sel_reg[ch0_input_sel])
        else $error("scanned input not selected");
    conv_space_a: assert property (kick_s |=> quiet_s)
        else $error("conversions overlap");
endmodule

bind asbc_top asbc_top_properties asbc_top_properties_inst (.mclk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sh_sample, .ch0_input_sel, .group_b_sel,
    .conv_channel, .conv_start, .irq);

`default_nettype wire

//--- verification/asbc_top_tb.sv
// Self-checking bench for the ADC sequencer
`include "asbc_defines.svh"
`default_nettype none

module asbc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, arst_n, reg_wr, reg_rd, timer_tick, ext_trig, group_b_sel;
    logic conv_start, conv_done, irq;
    logic [7:0] reg_addr, delay;
    logic [15:0] reg_wdata, reg_rdata, c1;
    logic [3:0] sh_sample, ch0_input_sel;
    logic [1:0] conv_channel;
    logic [9:0] conv_data;
    int error_cnt, checked, nconv, m, k;

    asbc_top asbc_top_inst (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .timer_tick, .ext_trig, .sh_sample, .ch0_input_sel, .group_b_sel,
        .conv_channel, .conv_start, .conv_done, .conv_data, .irq);
    asbc_conv_model asbc_conv_model_inst (.mclk, .arst_n, .conv_start, .conv_channel,
        .group_b_sel, .ch0_input_sel, .delay, .conv_done, .conv_data);

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Count requests so a trigger can wait for its conversions
    always @(posedge mclk) begin
        if (conv_start === 1'b1) nconv <= nconv + 1;
    end

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic compare(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input string n, input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        compare(n, reg_rdata, e);
    endtask

    // Expected result word as the model encodes it, unsigned format
    task automatic rde(input int e, input logic g, input logic [1:0] ch, input logic [3:0] s);
        rdc("result", 8'h40 + 8'(e * 4), {6'h00, 2'b10, g, ch, s, 1'b1});
    endtask

    // Stop sampling before reconfiguring so no sequence runs on mixed settings
    task automatic setup(input logic [15:0] ctl2, input logic [15:0] ctl1);
        wr(`ASBC_OFF_CTRL1, 16'h0000);
        repeat (4) @(posedge mclk);
        wr(`ASBC_OFF_STAT, 16'h0003);
        wr(`ASBC_OFF_CTRL2, ctl2);
        c1 = ctl1;
        wr(`ASBC_OFF_CTRL1, ctl1);
    endtask

    // One sequence: acquire, trigger from the chosen source, wait for its results
    task automatic run_seq(input int mode, input int nch);
        int i;
        int tgt;
        tgt = nconv + nch;
        repeat (4) @(posedge mclk);
        if (mode == 0) begin
            wr(`ASBC_OFF_CTRL1, c1 | 16'h0002);
        end else begin
            @(posedge mclk);
            timer_tick <= (mode == 1);
            ext_trig <= (mode == 2);
            repeat (3) @(posedge mclk);
            timer_tick <= 1'b0;
            ext_trig <= 1'b0;
        end
        for (i = 0; i < 2000 && nconv < tgt; i++) @(posedge mclk);
        if (nconv < tgt) begin
            error_cnt++;
            $display("Error conversion wait expected %0d seen %0d", tgt, nconv);
            report_and_stop();
        end
        repeat (int'(delay) + 16) @(posedge mclk);
    endtask

    initial begin
        {arst_n, reg_wr, reg_rd, timer_tick, ext_trig} = 5'b00000;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        delay = 8'h0c;
        c1 = 16'h0000;
        {error_cnt, checked} = 0;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        rdc("control two", `ASBC_OFF_CTRL2, 16'h0000);
        rdc("status", `ASBC_OFF_STAT, 16'h0000);
        // Split halves with alternating groups
        wr(`ASBC_OFF_MASK, 16'h0001);
        setup(16'h00c0, 16'h0001);
        run_seq(0, 1);
        rdc("control two", `ASBC_OFF_CTRL2, 16'h80c0);
        rde(0, 1'b0, 2'd0, 4'h0);
        compare("irq", {15'h0000, irq}, 16'h0001);
        wr(`ASBC_OFF_STAT, 16'h0003);
        run_seq(0, 1);
        rde(8, 1'b1, 2'd0, 4'h0);
        rdc("control two", `ASBC_OFF_CTRL2, 16'h00c0);
        // Every trigger source, interrupt masked
        wr(`ASBC_OFF_MASK, 16'h0000);
        for (m = 0; m < 3; m++) begin
            setup(16'h0000, 16'h0001 | 16'(m << 2));
            run_seq(m, 1);
            rdc("status", `ASBC_OFF_STAT, 16'h0003);
            rde(0, 1'b0, 2'd0, 4'h0);
        end
        compare("irq", {15'h0000, irq}, 16'h0000);
        wr(`ASBC_OFF_MASK, 16'h0001);
        repeat (3) @(posedge mclk);
        compare("irq", {15'h0000, irq}, 16'h0001);
        wr(8'h40, 16'hffff);
        rde(0, 1'b0, 2'd0, 4'h0);
        rdc("status", `ASBC_OFF_STAT, 16'h0003);
        wr(`ASBC_OFF_STAT, 16'h0003);
        repeat (3) @(posedge mclk);
        compare("irq", {15'h0000, irq}, 16'h0000);
        wr(`ASBC_OFF_CTRL1, 16'h0020);
        rdc("signed result", 8'h40, 16'h0001);
        // Four channels sequential, two sequences, slow converter
        delay <= 8'h28;
        setup(16'h0204, 16'h0001);
        for (k = 0; k < 4; k++) run_seq(0, 1);
        rdc("status", `ASBC_OFF_STAT, 16'h0000);
        for (k = 0; k < 4; k++) run_seq(0, 1);
        rdc("status", `ASBC_OFF_STAT, 16'h0003);
        for (k = 0; k < 8; k++) rde(k, 1'b0, 2'(k % 4), 4'h0);
        // Two channels sampled together
        delay <= 8'h0c;
        setup(16'h0100, 16'h0011);
        run_seq(0, 2);
        for (k = 0; k < 2; k++) rde(k, 1'b0, 2'(k), 4'h0);
        // Scan selects inputs 1, 2, 4 and 6; three sequences reach 1, 2 and 4, then restart at 1
        wr(`ASBC_OFF_SCAN, 16'h0056);
        setup(16'h0408, 16'h0001);
        for (k = 0; k < 3; k++) run_seq(0, 1);
        rdc("status", `ASBC_OFF_STAT, 16'h0003);
        rde(0, 1'b0, 2'd0, 4'h1);
        rde(1, 1'b0, 2'd0, 4'h2);
        rde(2, 1'b0, 2'd0, 4'h4);
        wr(`ASBC_OFF_STAT, 16'h0003);
        run_seq(0, 1);
        rde(0, 1'b0, 2'd0, 4'h1);
        report_and_stop();
    end
endmodule

`default_nettype wire

//--- verilog/asbc_defines.svh
// Register offsets, field positions, reset values and timing counts for the ADC sequencer
`ifndef ASBC_DEFINES_SVH
`define ASBC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ASBC_OFF_CTRL1 8'h00
`define ASBC_OFF_CTRL2 8'h04
`define ASBC_OFF_SCAN 8'h08
`define ASBC_OFF_STAT 8'h0c
`define ASBC_OFF_MASK 8'h10
`define ASBC_OFF_MUXA 8'h14
`define ASBC_OFF_MUXB 8'h18
`define ASBC_OFF_BUF 8'h40
`define ASBC_OFF_BUF_END 8'h7c

// ----------------------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------------------
`define ASBC_C1_SAMPLE_START_BIT 0
`define ASBC_C1_GO 1
`define ASBC_C1_TRIG_LO 2
`define ASBC_C1_TRIG_HI 3
`define ASBC_C1_SIMSEL 4
`define ASBC_C1_FMT 5

// ----------------------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------------------
`define ASBC_C2_SPI_LO 2
`define ASBC_C2_SPI_HI 5
`define ASBC_C2_SPLIT 6
`define ASBC_C2_ALT 7
`define ASBC_C2_CHC_LO 8
`define ASBC_C2_CHC_HI 9
`define ASBC_C2_SCAN 10
`define ASBC_C2_HALF 15

// ----------------------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------------------
`define ASBC_ST_IRQ 0
`define ASBC_ST_DONE 1
`define ASBC_RST_CTRL 16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ASBC_CONV_NS 240
`define ASBC_CLK_NS 20
`define ASBC_CONV_CYC ((`ASBC_CONV_NS + `ASBC_CLK_NS - 1) / `ASBC_CLK_NS)

`endif

//--- verilog/asbc_pkg.sv
// Types shared by the ADC sequencer files
`default_nettype none

package asbc_pkg;
    typedef enum logic [2:0] {
        ASBC_IDLE = 3'b000,
        ASBC_SAMPLE = 3'b001,
        ASBC_CONVERT = 3'b010,
        ASBC_STORE = 3'b011
    } asbc_state_t;

    typedef enum logic [1:0] {
        ASBC_TRIG_BIT = 2'b00,
        ASBC_TRIG_TIMER = 2'b01,
        ASBC_TRIG_EXT = 2'b10
    } asbc_trig_t;
endpackage

`default_nettype wire

//--- verilog/asbc_result_store.sv
// Sixteen-entry, 10-bit result store with formatted 16-bit read port
`default_nettype none

module asbc_result_store
    import asbc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Converter write side
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [9:0] wr_data,
    // Reader side
    input wire logic [3:0] rd_addr,
    input wire logic fmt_signed,
    output logic [15:0] rd_word
);
    logic [9:0] mem_reg [16];
    logic [9:0] mem_next [16];
    logic [9:0] raw;

    // Per-entry write select; software has no write path into the store
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_ent
            always_comb begin
                mem_next[gi] = mem_reg[gi];
                if (wr_en && wr_addr == 4'(gi)) begin
                    mem_next[gi] = wr_data;
                end
            end
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    mem_reg[gi] <= 10'h000;
                end else begin
                    mem_reg[gi] <= mem_next[gi];
                end
            end
        end
    endgenerate

    // Formatting: plain integer, or signed with the offset removed
    always_comb begin
        raw = mem_reg[rd_addr];
        if (fmt_signed) begin
            rd_word = {{6{~raw[9]}}, ~raw[9], raw[8:0]};
        end else begin
            rd_word = {6'h00, raw};
        end
    end
endmodule

`default_nettype wire

//--- verilog/asbc_top.sv
// ADC sequencing and result-buffer controller with register port and interrupt
//
// Summary of operation
// - Sixteen 10-bit results, read as formatted 16-bit words, not software-writable.
// - Setting the sample start bit begins acquisition.
// - Chosen trigger (bit, timer, external) ends sampling and starts conversion.
// - Every result stored; flag and done set after programmed sequences complete.
// - Sequential mode samples chosen channels one sample clock each.
// - Simultaneous mode samples all chosen channels together, then converts in turn.
// - Channel count chooses channel zero, zero and one, or zero to three.
// - Samples-per-interrupt value n gives n+1 sequences.
// - Split mode uses two eight-word halves, swapping at each interrupt.
// - Alternate select clear uses only input group A.
// - Alternate select set alternates group A and group B each sequence.
// - Scan enable steps channel zero's group A input over selected inputs.
// - Scan goes low to high and restarts after each interrupt.
`include "asbc_defines.svh"
`default_nettype none

module asbc_top
    import asbc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Trigger sources
    input wire logic timer_tick,
    input wire logic ext_trig,
    // Analog front end
    output logic [3:0] sh_sample,
    output logic [3:0] ch0_input_sel,
    output logic group_b_sel,
    output logic [1:0] conv_channel,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [9:0] conv_data,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [15:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
    logic [15:0] scan_reg, scan_next, mask_reg, mask_next;
    logic [1:0] stat_reg, stat_next;
    logic [15:0] rdata_reg, rdata_next;
    asbc_state_t state_reg, state_next;
    logic [1:0] ch_reg, ch_next;
    logic [3:0] seq_reg, seq_next;
    logic [3:0] wptr_reg, wptr_next;
    logic half_reg, half_next;
    logic grp_b_reg, grp_b_next;
    logic [3:0] scan_pos_reg, scan_pos_next;
    logic [3:0] sh_reg, sh_next;
    logic start_reg, start_next;
    logic [1:0] tmr_sync_reg, ext_sync_reg, done_sync_reg;
    logic ext_old_reg, done_old_reg;
    logic [9:0] data_s1_reg, data_s2_reg;
    logic [7:0] timeout_reg, timeout_next;
    logic irq_reg;

    // Pin inputs pass two flops before any logic looks at them
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_sync_reg <= 2'b00;
            ext_sync_reg <= 2'b00;
            done_sync_reg <= 2'b00;
            data_s1_reg <= 10'h000;
            data_s2_reg <= 10'h000;
            ext_old_reg <= 1'b0;
            done_old_reg <= 1'b0;
        end else begin
            tmr_sync_reg <= {tmr_sync_reg[0], timer_tick};
            ext_sync_reg <= {ext_sync_reg[0], ext_trig};
            done_sync_reg <= {done_sync_reg[0], conv_done};
            data_s1_reg <= conv_data;
            data_s2_reg <= data_s1_reg;
            ext_old_reg <= ext_sync_reg[1];
            done_old_reg <= done_sync_reg[1];
        end
    end

    // ------------------------------------------------------------------------
    // Decoded fields
    // ------------------------------------------------------------------------
    logic [1:0] chc;
    logic [1:0] last_ch;
    logic [3:0] spi;
    logic trig_hit, done_rise, seq_end, irq_event;
    logic [3:0] next_scan;
    logic found;
    logic [15:0] buf_word;
    logic [3:0] buf_idx;

    assign chc = ctrl2_reg[`ASBC_C2_CHC_HI:`ASBC_C2_CHC_LO];
    assign last_ch = (chc == 2'b00) ? 2'd0 : (chc == 2'b01) ? 2'd1 : 2'd3;
    assign spi = ctrl2_reg[`ASBC_C2_SPI_HI:`ASBC_C2_SPI_LO];
    assign done_rise = done_sync_reg[1] & ~done_old_reg;
    assign buf_idx = reg_addr[5:2];

    always_comb begin
        case (asbc_trig_t'(ctrl1_reg[`ASBC_C1_TRIG_HI:`ASBC_C1_TRIG_LO]))
            ASBC_TRIG_BIT: trig_hit = ctrl1_reg[`ASBC_C1_GO];
            ASBC_TRIG_TIMER: trig_hit = tmr_sync_reg[1];
            ASBC_TRIG_EXT: trig_hit = ext_sync_reg[1] & ~ext_old_reg;
            default: trig_hit = 1'b0;
        endcase
    end

    // next selected scan input above the current one, lowest first
    always_comb begin
        next_scan = scan_pos_reg;
        found = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (!found && i > int'(scan_pos_reg) && scan_reg[i]) begin
                next_scan = 4'(i);
                found = 1'b1;
            end
        end
    end

    // first selected input, used after each interrupt
    function automatic logic [3:0] first_scan(input logic [15:0] sel);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (sel[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    logic store_wr;
    always_comb begin
        state_next = state_reg;
        ch_next = ch_reg;
        seq_next = seq_reg;
        wptr_next = wptr_reg;
        half_next = half_reg;
        grp_b_next = grp_b_reg;
        scan_pos_next = scan_pos_reg;
        sh_next = 4'h0;
        start_next = 1'b0;
        timeout_next = timeout_reg;
        seq_end = 1'b0;
        irq_event = 1'b0;
        store_wr = 1'b0;
        case (state_reg)
            ASBC_IDLE: begin
                // acquisition begins on the start bit
                if (ctrl1_reg[`ASBC_C1_SAMPLE_START_BIT]) begin
                    state_next = ASBC_SAMPLE;
                    ch_next = 2'd0;
                    seq_next = 4'h0;
                    scan_pos_next = ctrl2_reg[`ASBC_C2_SCAN] ? first_scan(scan_reg) : 4'h0;
                end
            end
            ASBC_SAMPLE: begin
                // simultaneous holds every chosen channel at once
                if (ctrl1_reg[`ASBC_C1_SIMSEL]) begin
                    sh_next = (last_ch == 2'd0) ? 4'h1 : (last_ch == 2'd1) ? 4'h3 : 4'hf;
                end else begin
                    // sequential holds one channel per sample clock
                    sh_next = 4'h1 << ch_reg;
                end
                // Cleared start bit stops acquisition between sequences
                if (!ctrl1_reg[`ASBC_C1_SAMPLE_START_BIT] && ch_reg == 2'd0) begin
                    state_next = ASBC_IDLE;
                end else if (trig_hit) begin
                    state_next = ASBC_CONVERT;
                    start_next = 1'b1;
                    timeout_next = 8'(`ASBC_CONV_CYC);
                end
            end
            ASBC_CONVERT: begin
                if (timeout_reg != 8'h00) begin
                    timeout_next = timeout_reg - 8'h01;
                end
                if (done_rise && timeout_reg == 8'h00) begin
                    state_next = ASBC_STORE;
                end
            end
            ASBC_STORE: begin
                // each result goes into the store
                store_wr = 1'b1;
                wptr_next = wptr_reg + 4'h1;
                if (ch_reg != last_ch) begin
                    ch_next = ch_reg + 2'd1;
                    if (ctrl1_reg[`ASBC_C1_SIMSEL]) begin
                        state_next = ASBC_CONVERT;
                        start_next = 1'b1;
                        timeout_next = 8'(`ASBC_CONV_CYC);
                    end else begin
                        state_next = ASBC_SAMPLE;
                    end
                end else begin
                    seq_end = 1'b1;
                    ch_next = 2'd0;
                    state_next = ASBC_SAMPLE;
                    grp_b_next = ctrl2_reg[`ASBC_C2_ALT] & ~grp_b_reg;
                    // step channel zero scan per sequence
                    if (ctrl2_reg[`ASBC_C2_SCAN]) begin
                        scan_pos_next = found ? next_scan : first_scan(scan_reg);
                    end
                    if (seq_reg == spi) begin
                        irq_event = 1'b1;
                        seq_next = 4'h0;
                        scan_pos_next = first_scan(scan_reg);
                        // split mode swaps halves per interrupt
                        if (ctrl2_reg[`ASBC_C2_SPLIT]) begin
                            half_next = ~half_reg;
                            wptr_next = {~half_reg, 3'h0};
                        end else begin
                            wptr_next = 4'h0;
                        end
                    end else begin
                        seq_next = seq_reg + 4'h1;
                    end
                end
                if (!ctrl1_reg[`ASBC_C1_SAMPLE_START_BIT]) begin
                    state_next = ASBC_IDLE;
                end
            end
            default: state_next = ASBC_IDLE;
        endcase
        // group A only while alternation is off
        if (!ctrl2_reg[`ASBC_C2_ALT]) begin
            grp_b_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ASBC_IDLE;
            ch_reg <= 2'd0;
            seq_reg <= 4'h0;
            wptr_reg <= 4'h0;
            half_reg <= 1'b0;
            grp_b_reg <= 1'b0;
            scan_pos_reg <= 4'h0;
            sh_reg <= 4'h0;
            start_reg <= 1'b0;
            timeout_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            ch_reg <= ch_next;
            seq_reg <= seq_next;
            wptr_reg <= wptr_next;
            half_reg <= half_next;
            grp_b_reg <= grp_b_next;
            scan_pos_reg <= scan_pos_next;
            sh_reg <= sh_next;
            start_reg <= start_next;
            timeout_reg <= timeout_next;
        end
    end

    // result store, no software write path
    asbc_result_store u_store (
        .mclk(mclk),
        .arst_n(arst_n),
        .wr_en(store_wr),
        .wr_addr(wptr_reg),
        .wr_data(data_s2_reg),
        .rd_addr(buf_idx),
        .fmt_signed(ctrl1_reg[`ASBC_C1_FMT]),
        .rd_word(buf_word)
    );

    // ------------------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------------------
    always_comb begin
        ctrl1_next = ctrl1_reg;
        ctrl2_next = ctrl2_reg;
        scan_next = scan_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        rdata_next = 16'h0000;
        // Trigger bit is a one-shot so one write gives one trigger: one conversion, or one per chosen channel in simultaneous mode
        if (state_reg == ASBC_SAMPLE && trig_hit) begin
            ctrl1_next[`ASBC_C1_GO] = 1'b0;
        end
        if (reg_wr) begin
            case (reg_addr)
                `ASBC_OFF_CTRL1: ctrl1_next = {10'h000, reg_wdata[5:0]};
                `ASBC_OFF_CTRL2: ctrl2_next = {5'h00, reg_wdata[10:2], 2'b00};
                `ASBC_OFF_SCAN: scan_next = reg_wdata;
                `ASBC_OFF_MASK: mask_next = {14'h0000, reg_wdata[1:0]};
                `ASBC_OFF_STAT: stat_next = stat_reg & ~reg_wdata[1:0];
                default: ;
            endcase
        end
        // flag and done set win over clear
        if (irq_event) begin
            stat_next = 2'b11;
        end
        if (reg_rd) begin
            if (reg_addr >= `ASBC_OFF_BUF && reg_addr <= `ASBC_OFF_BUF_END) begin
                rdata_next = buf_word;
            end else begin
                case (reg_addr)
                    `ASBC_OFF_CTRL1: rdata_next = ctrl1_reg;
                    `ASBC_OFF_CTRL2: rdata_next = {half_reg, ctrl2_reg[14:0]};
                    `ASBC_OFF_SCAN: rdata_next = scan_reg;
                    `ASBC_OFF_STAT: rdata_next = {14'h0000, stat_reg};
                    `ASBC_OFF_MASK: rdata_next = mask_reg;
                    `ASBC_OFF_MUXA: rdata_next = {12'h000, scan_pos_reg};
                    `ASBC_OFF_MUXB: rdata_next = {15'h0000, grp_b_reg};
                    default: rdata_next = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_reg <= `ASBC_RST_CTRL;
            ctrl2_reg <= `ASBC_RST_CTRL;
            scan_reg <= `ASBC_RST_CTRL;
            mask_reg <= `ASBC_RST_CTRL;
            stat_reg <= 2'b00;
            rdata_reg <= 16'h0000;
            irq_reg <= 1'b0;
        end else begin
            ctrl1_reg <= ctrl1_next;
            ctrl2_reg <= ctrl2_next;
            scan_reg <= scan_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            rdata_reg <= rdata_next;
            irq_reg <= |(stat_next & mask_next[1:0]);
        end
    end

    // Outputs straight from flops
    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;
    assign sh_sample = sh_reg;
    assign conv_start = start_reg;
    assign conv_channel = ch_reg;
    assign group_b_sel = grp_b_reg;
    assign ch0_input_sel = scan_pos_reg;
endmodule

`default_nettype wire
